// file: verilog/cbap_addr_phase.sv
`timescale 1ns/1ps
`include "cbap_params.svh"

// Contract
// - A3-A2 are outputs only and never sampled during cache inquiry.
// - memory cycles drive all thirty address bits, full 4G-byte range.
// - port cycles, except coprocessor, drive A31-A16 low for 64-Kbyte space.
// - strobe asserts only while address, byte enables and cycle type are driven.
// - strobe on a memory cycle marks management memory space when requested; port cycles never do.
// - strobe floats during hold acknowledge or float state.
// - address float request floats A31-A2 from the next clock cycle.
// - during float request only the address bus is disabled; cycle completes.
// - no new cycles during float request except inquiry write-backs.
// - float request sampled at reset; asserted at release runs self test first.
module cbap_addr_phase (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic address_float_request,
    input wire logic hold_ack,
    input wire logic float_req,
    input wire logic cyc_req,
    input wire logic cyc_writeback,
    input wire logic [`CBAP_ADDR_W-1:0] cyc_addr,
    input wire logic [`CBAP_BE_W-1:0] cyc_be_n,
    input wire logic cyc_mem,
    input wire logic cyc_data,
    input wire logic cyc_write,
    input wire logic cyc_copro,
    input wire logic cyc_smm,
    input wire logic cyc_end,
    output logic cyc_ack,
    input wire logic [`CBAP_ADDR_W-1:0] addr_in,
    output logic [`CBAP_ADDR_W-1:0] addr_out,
    output logic addr_oe,
    output logic [`CBAP_BE_W-1:0] byte_lane_enables_n,
    output logic mem_io_sel,
    output logic data_code_sel,
    output logic write_read_sel,
    output logic cycle_oe,
    output logic address_strobe_n,
    output logic address_strobe_oe,
    output logic smm_space,
    output logic [`CBAP_ADDR_W-1:0] inquiry_addr,
    output logic inquiry_valid,
    output logic bist_running
);
    cbap_pkg::cbap_state_t state;
    cbap_pkg::cbap_state_t next_state;
    logic first_clk;
    logic next_first_clk;
    logic bist_start;
    logic bist_busy;
    logic [`CBAP_ADDR_W-1:0] next_addr_out;
    logic next_addr_oe;
    logic [`CBAP_BE_W-1:0] next_be_n;
    logic next_mio;
    logic next_dc;
    logic next_wr;
    logic next_cycle_oe;
    logic next_strobe_n;
    logic next_strobe_oe;
    logic next_smm;
    logic [`CBAP_ADDR_W-1:0] next_inq;
    logic next_inq_valid;
    logic start_ok;
    logic strap;
    logic next_strap;
    logic wb_cycle;
    logic next_wb_cycle;

    // port cycle address: upper sixteen lines forced low unless coprocessor
    function automatic logic [`CBAP_ADDR_W-1:0] cbap_map_addr(
        input logic [`CBAP_ADDR_W-1:0] a,
        input logic mem,
        input logic copro
    );
        logic [`CBAP_ADDR_W-1:0] r;
        r = a;
        if (!mem && !copro) begin
            r[`CBAP_ADDR_W-1 -: `CBAP_IO_HI_W] = {`CBAP_IO_HI_W{1'b0}};
        end
        return r;
    endfunction : cbap_map_addr

    // the pins belong to someone else while any float input stands
    function automatic logic cbap_bus_taken(
        input logic afr,
        input logic hold,
        input logic flt
    );
        return afr || hold || flt;
    endfunction : cbap_bus_taken

    cbap_bist u_bist (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(bist_start),
        .busy(bist_busy),
        .done()
    );

    // strap holds the float request seen at the previous edge; while first_clk is set, that edge had reset applied
    assign bist_start = first_clk && strap;
    assign bist_running = bist_busy;
    // a new cycle only when the address bus is ours again, or a write-back
    assign start_ok = !cbap_bus_taken(address_float_request, hold_ack, float_req)
        || cyc_writeback;

    // sequencer and address phase outputs
    always_comb begin
        next_state = state;
        next_first_clk = 1'b0;
        // strap follows the pin every edge; only its value at release matters
        next_strap = address_float_request;
        next_wb_cycle = wb_cycle;
        next_addr_out = addr_out;
        next_be_n = byte_lane_enables_n;
        next_mio = mem_io_sel;
        next_dc = data_code_sel;
        next_wr = write_read_sel;
        next_smm = smm_space;
        next_cycle_oe = !cbap_bus_taken(1'b0, hold_ack, float_req);
        next_strobe_n = 1'b1;
        next_strobe_oe = !cbap_bus_taken(1'b0, hold_ack, float_req);
        // float request floats address one clock later; cycle keeps running
        next_addr_oe = !cbap_bus_taken(address_float_request, hold_ack, float_req);
        // latch only A31-A4 of the inquiry; A3-A2 are output only
        next_inq = inquiry_addr;
        next_inq[`CBAP_INQ_LSB-1:0] = 2'h0;
        next_inq_valid = address_float_request && !addr_oe;
        if (next_inq_valid) begin
            next_inq[`CBAP_ADDR_W-1:`CBAP_INQ_LSB] = addr_in[`CBAP_ADDR_W-1:`CBAP_INQ_LSB];
        end
        cyc_ack = 1'b0;
        case (state)
            cbap_pkg::CBAP_IDLE: begin
                if (bist_start || bist_busy) begin
                    next_state = cbap_pkg::CBAP_BIST;
                end else if (cyc_req && start_ok && (addr_oe || cyc_writeback)) begin
                    next_addr_out = cbap_map_addr(cyc_addr, cyc_mem, cyc_copro);
                    next_be_n = cyc_be_n;
                    next_mio = cyc_mem;
                    next_dc = cyc_data;
                    next_wr = cyc_write;
                    next_smm = cyc_smm;
                    next_wb_cycle = cyc_writeback;
                    next_cycle_oe = 1'b1;
                    if (cyc_writeback) begin
                        next_addr_oe = 1'b1;
                    end
                    next_state = cbap_pkg::CBAP_ADDR;
                    cyc_ack = 1'b1;
                end
            end
            cbap_pkg::CBAP_BIST: begin
                // no bus cycle may be issued until self test ends
                if (!bist_busy && !bist_start) begin
                    next_state = cbap_pkg::CBAP_IDLE;
                end
            end
            cbap_pkg::CBAP_ADDR: begin
                // a write-back keeps its address on the pins through its strobe
                if (wb_cycle) begin
                    next_addr_oe = 1'b1;
                end
                // strobe only while phase signals are on the pins and stay there
                if (addr_oe && cycle_oe && next_addr_oe && next_cycle_oe) begin
                    next_strobe_n = 1'b0;
                    next_smm = smm_space && mem_io_sel;
                    next_state = cbap_pkg::CBAP_WAIT;
                end else if (!cbap_bus_taken(address_float_request, hold_ack, float_req)) begin
                    next_addr_oe = 1'b1;
                end
            end
            cbap_pkg::CBAP_WAIT: begin
                if (cyc_end) begin
                    next_state = cbap_pkg::CBAP_IDLE;
                end
            end
            default: begin
                next_state = cbap_pkg::CBAP_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        // sampled in reset as well, so the strap is seen before release
        strap <= next_strap;
        if (!reset_n) begin
            state <= cbap_pkg::CBAP_IDLE;
            wb_cycle <= 1'b0;
            first_clk <= 1'b1;
            addr_out <= {`CBAP_ADDR_W{1'b0}};
            addr_oe <= 1'b0;
            byte_lane_enables_n <= {`CBAP_BE_W{1'b1}};
            mem_io_sel <= 1'b0;
            data_code_sel <= 1'b0;
            write_read_sel <= 1'b0;
            cycle_oe <= 1'b0;
            address_strobe_n <= 1'b1;
            address_strobe_oe <= 1'b0;
            smm_space <= 1'b0;
            inquiry_addr <= {`CBAP_ADDR_W{1'b0}};
            inquiry_valid <= 1'b0;
        end else begin
            state <= next_state;
            wb_cycle <= next_wb_cycle;
            first_clk <= next_first_clk;
            addr_out <= next_addr_out;
            addr_oe <= next_addr_oe;
            byte_lane_enables_n <= next_be_n;
            mem_io_sel <= next_mio;
            data_code_sel <= next_dc;
            write_read_sel <= next_wr;
            cycle_oe <= next_cycle_oe;
            address_strobe_n <= next_strobe_n;
            address_strobe_oe <= next_strobe_oe;
            smm_space <= next_smm;
            inquiry_addr <= next_inq;
            inquiry_valid <= next_inq_valid;
        end
    end
endmodule : cbap_addr_phase

// file: include/cbap_params.svh
`ifndef CBAP_PARAMS_SVH
`define CBAP_PARAMS_SVH

// address and byte lane widths
`define CBAP_ADDR_W 30
`define CBAP_BE_W 4
// bit index of A4 within the A31..A2 vector
`define CBAP_INQ_LSB 2
// number of A31..A16 bits forced low on port cycles
`define CBAP_IO_HI_W 16
// self test length in clocks (choice; no figure is given)
`define CBAP_BIST_CYCLES 8'h20
`define CBAP_CNT_W 8

`endif

// file: include/cbap_pkg.sv
package cbap_pkg;
    // address phase sequencer states, one-hot
    typedef enum logic [3:0] {
        CBAP_IDLE = 4'h1,
        CBAP_BIST = 4'h2,
        CBAP_ADDR = 4'h4,
        CBAP_WAIT = 4'h8
    } cbap_state_t;
endpackage : cbap_pkg

// file: verilog/cbap_bist.sv
`timescale 1ns/1ps
`include "cbap_params.svh"

// self test sequencer: runs a fixed count once when armed at reset release
module cbap_bist (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic start,
    output logic busy,
    output logic done
);
    logic [`CBAP_CNT_W-1:0] count;
    logic [`CBAP_CNT_W-1:0] next_count;
    logic next_busy;
    logic next_done;

    // count down while busy; done pulses one cycle at the end
    always_comb begin
        next_count = count;
        next_busy = busy;
        next_done = 1'b0;
        if (start && !busy) begin
            next_count = `CBAP_BIST_CYCLES;
            next_busy = 1'b1;
        end else if (busy) begin
            if (count == {`CBAP_CNT_W{1'b0}}) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else begin
                next_count = count - 8'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            count <= {`CBAP_CNT_W{1'b0}};
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            count <= next_count;
            busy <= next_busy;
            done <= next_done;
        end
    end
endmodule : cbap_bist

// file: tb/cbap_addr_phase_checker.sv
`timescale 1ns/1ps
`include "cbap_params.svh"
// watches the address phase pins against the request side
module cbap_checker (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic address_float_request,
    input wire logic hold_ack,
    input wire logic float_req,
    input wire logic cyc_req,
    input wire logic cyc_writeback,
    input wire logic cyc_mem,
    input wire logic cyc_copro,
    input wire logic cyc_ack,
    input wire logic [`CBAP_ADDR_W-1:0] addr_out,
    input wire logic addr_oe,
    input wire logic cycle_oe,
    input wire logic address_strobe_n,
    input wire logic address_strobe_oe,
    input wire logic bist_running
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // strobe is a single low cycle two edges after the request is taken
    a_strobe_lag: assert property (cyc_ack |-> ##2 !address_strobe_n)
        else $error("strobe not two edges after take");
    a_strobe_pulse: assert property (!address_strobe_n |=> address_strobe_n)
        else $error("strobe longer than one cycle");
    a_strobe_valid: assert property (!address_strobe_n |-> addr_oe && cycle_oe)
        else $error("strobe while pins undriven");
    a_io_upper: assert property (cyc_ack && !cyc_mem && !cyc_copro |=> addr_out[29:14] == 16'h0)
        else $error("port cycle upper address not low");
    a_strobe_float: assert property (hold_ack || float_req |=> !address_strobe_oe)
        else $error("strobe driven in hold");
    a_float_next: assert property ($rose(address_float_request) && !cyc_req |=> !addr_oe)
        else $error("address not floated next cycle");
    // only write-backs may start while the float request stands
    a_no_new: assert property (address_float_request && !cyc_writeback |-> !cyc_ack)
        else $error("cycle started during float request");
    a_bist_quiet: assert property (bist_running |-> !cyc_ack)
        else $error("cycle started during self test");
    a_drive_first: assert property (cyc_ack |=> addr_oe)
        else $error("address not driven for new cycle");
endmodule : cbap_checker

bind cbap_addr_phase cbap_checker u_chk (.mclk, .reset_n, .address_float_request, .hold_ack,
    .float_req, .cyc_req, .cyc_writeback, .cyc_mem, .cyc_copro, .cyc_ack, .addr_out, .addr_oe,
    .cycle_oe, .address_strobe_n, .address_strobe_oe, .bist_running);

// file: tb/cbap_sys_model.sv
`timescale 1ns/1ps
// chipset side: float request, inquiry address on the shared pins, cycle end
module cbap_sys_model (
    input wire logic mclk,
    input wire logic afr_cmd,
    input wire logic [29:0] inq,
    input wire logic slow,
    input wire logic [29:0] addr_out,
    input wire logic addr_oe,
    input wire logic address_strobe_n,
    output logic address_float_request,
    output logic [29:0] addr_in,
    output logic cyc_end = 1'h0
);
    logic [29:0] pat = 30'h0;
    logic [3:0] cnt = 4'h0;
    // also held across reset release to ask for self test
    assign address_float_request = afr_cmd;
    // released pins wander so a stale address never looks valid
    assign addr_in = addr_oe ? addr_out : address_float_request ? inq : pat;
    // end each cycle two or seven clocks after its strobe
    always @(posedge mclk) begin
        pat <= {pat[28:0], ~pat[29]};
        cyc_end <= cnt == 4'h1;
        if (!address_strobe_n) cnt <= slow ? 4'h6 : 4'h1;
        else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
endmodule : cbap_sys_model

// file: tb/tb_cpu_bus_address_phase.sv
`timescale 1ns/1ps
`include "cbap_params.svh"
module tb_cpu_bus_address_phase;
    logic mclk = 0, reset_n = 0, hold_ack = 0, float_req = 0, cyc_req = 0, slow = 0;
    logic cyc_mem = 0, cyc_copro = 0, cyc_writeback = 0, afr_cmd = 0;
    logic [36:0] fld = '0;
    logic [29:0] cyc_addr, addr_in, addr_out, inquiry_addr, ea, inq = '0;
    logic [3:0] cyc_be_n, byte_lane_enables_n;
    logic cyc_data, cyc_write, cyc_smm, cyc_end, cyc_ack, addr_oe, mem_io_sel, data_code_sel;
    logic write_read_sel, cycle_oe, address_strobe_n, address_strobe_oe, smm_space;
    logic inquiry_valid, bist_running, address_float_request;
    logic [37:0] q[$];
    integer checks = 0, miscompares = 0, n = 0;
    wire [37:0] pins = {addr_out, byte_lane_enables_n, mem_io_sel, data_code_sel,
        write_read_sel, smm_space};
    assign {cyc_addr, cyc_be_n, cyc_data, cyc_write, cyc_smm} = fld;
    cbap_addr_phase dut (.mclk, .reset_n, .address_float_request, .hold_ack, .float_req,
        .cyc_req, .cyc_writeback, .cyc_addr, .cyc_be_n, .cyc_mem, .cyc_data, .cyc_write,
        .cyc_copro, .cyc_smm, .cyc_end, .cyc_ack, .addr_in, .addr_out, .addr_oe,
        .byte_lane_enables_n, .mem_io_sel, .data_code_sel, .write_read_sel, .cycle_oe,
        .address_strobe_n, .address_strobe_oe, .smm_space, .inquiry_addr, .inquiry_valid,
        .bist_running);
    cbap_sys_model sys (.mclk, .afr_cmd, .inq, .slow, .addr_out, .addr_oe,
        .address_strobe_n, .address_float_request, .addr_in, .cyc_end);
    initial forever #12.5 mclk = ~mclk;
    task chk(input logic [37:0] seen, input logic [37:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task tick(input integer k);
        repeat (k) @(posedge mclk);
        #2;
    endtask : tick
    task rst(input logic s);
        reset_n = 0;
        afr_cmd = s;
        tick(10);
        reset_n = 1;
        tick(1);
        afr_cmd = 0;
        tick(1);
        chk(bist_running, s);
    endtask : rst
    // one request; its expected pins are queued before it is raised
    task issue(input logic m, input logic cp, input logic wb);
        fld = 37'({$urandom, $urandom});
        fld[0] = fld[0] & m;
        ea = fld[36:7];
        if (!m && !cp) ea[29:14] = '0;
        q.push_back({ea, fld[6:3], m, fld[2:1], fld[0]});
        {cyc_mem, cyc_copro, cyc_writeback, cyc_req} = {m, cp, wb, 1'h1};
        n = 0;
        #1;
        while (cyc_ack !== 1'h1 && n < 80) begin
            tick(1);
            #1;
            n++;
        end
        tick(1);
        cyc_req = 0;
        chk(n < 80, 1);
        tick(4);
    endtask : issue
    // each strobe must show the oldest queued request
    always @(posedge mclk) begin
        #1;
        if (address_strobe_n === 1'h0) chk(pins, q.pop_front());
    end
    initial begin
        #60000;
        miscompares++;
        results;
    end
    initial begin
        void'($urandom(32'h1F17C78A));
        rst(1);
        issue(1, 0, 0);
        chk(n > `CBAP_BIST_CYCLES - 4, 1);
        repeat (12) begin
            slow = 1'($urandom);
            issue(1'($urandom), 1'($urandom), 0);
        end
        inq = 30'($urandom);
        afr_cmd = 1;
        tick(2);
        chk(addr_oe, 0);
        tick(2);
        chk({inquiry_valid, inquiry_addr}, {1'h1, inq[29:2], 2'h0});
        issue(1, 0, 1);
        chk(n < 3, 1);
        // a plain request waits until the float request is dropped
        fork
            begin
                tick(15);
                afr_cmd = 0;
            end
            issue(0, 0, 0);
        join
        chk(n > 13, 1);
        hold_ack = 1;
        tick(3);
        chk(address_strobe_oe, 0);
        {hold_ack, float_req} = 2'h1;
        tick(3);
        float_req = 0;
        rst(0);
        issue(1, 0, 0);
        results;
    end
endmodule : tb_cpu_bus_address_phase
